// ==== core/sdsc_pkg.sv ====
// Package for the skew delay serial configuration block.
// Assumes a core clock and a separate programming clock from the host.
package sdsc_pkg;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [1:0] ADDR_TEST_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_RED_DELAY = 2'h1;
    localparam logic [1:0] ADDR_GREEN_DELAY = 2'h2;
    localparam logic [1:0] ADDR_BLUE_DELAY = 2'h3;
    localparam int REG_WIDTH = 5;
    localparam int WORD_BITS = 8;
    localparam logic [4:0] REG_RESET = 5'h00;
    localparam logic OP_WRITE = 1'h0;
    localparam int TEST_MODE_BIT = 0;
    localparam int SLICE_LSB = 1;
    localparam int SLICE_MSB = 4;
    // Bit positions within a word: 0 op, 1..2 address, 3..7 payload
    localparam logic [2:0] POS_OP = 3'h0;
    localparam logic [2:0] POS_ADDR_LO = 3'h2;
    localparam logic [2:0] POS_PAYLOAD = 3'h3;
    localparam logic [2:0] POS_LAST = 3'h7;
    // ****************************************
    // Timing
    // ****************************************
    localparam int DELAY_STEP_PS = 2000;
    localparam int SLICE_STEP_MV = 50;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {SDSC_IDLE, SDSC_ADDR, SDSC_DATA, SDSC_SKIP} sdsc_phase_e;

    typedef struct packed {
        logic [4:0] test_control;
        logic [4:0] red_delay;
        logic [4:0] green_delay;
        logic [4:0] blue_delay;
    } sdsc_regs_s;

    typedef struct packed {
        logic test_mode;
        logic signed [3:0] slice_code;
        logic [4:0] red_stages;
        logic [4:0] green_stages;
        logic [4:0] blue_stages;
        logic chip_on;
        logic gain_double;
    } sdsc_ctrl_s;
endpackage : sdsc_pkg

// ==== core/sdsc_serial_rx.sv ====
// Serial receiver on the programming clock, falling edge.
// Assumes select and data are stable around each falling clock edge.
`timescale 1ns/100ps
module sdsc_serial_rx (
    input wire logic clk_n_in,
    input wire logic rst_n_in,
    input wire logic select_n_in,
    input wire logic data_in,
    output sdsc_pkg::sdsc_regs_s regs_out
);
    typedef struct packed {
        sdsc_pkg::sdsc_phase_e phase;
        logic [2:0] bit_pos;
        logic [1:0] addr;
        sdsc_pkg::sdsc_regs_s regs;
    } sdsc_rx_s;

    sdsc_rx_s st;
    sdsc_rx_s next_st;
    logic fresh;
    logic [2:0] pos;

    // ****************************************
    // Word start marker
    // ****************************************
    // The host clock stands still between frames, so select high must
    // restart the count without waiting for a clock edge
    always_ff @(negedge clk_n_in or negedge rst_n_in or posedge select_n_in)
    begin
        if (!rst_n_in)
        begin
            fresh <= 1'b1;
        end
        else if (select_n_in)
        begin
            fresh <= 1'b1;
        end
        else
        begin
            fresh <= 1'b0;
        end
    end

    // ****************************************
    // Word decode
    // ****************************************
    always_comb
    begin
        next_st = st;
        pos = fresh ? 3'h0 : st.bit_pos;
        if (select_n_in)
        begin
            // Select high: end any partial word; bits already shifted in stay
            next_st.bit_pos = 3'h0;
            next_st.phase = sdsc_pkg::SDSC_IDLE;
        end
        else
        begin
            next_st.bit_pos = pos + 3'h1;
            if (pos == sdsc_pkg::POS_OP)
            begin
                // Read is unsupported, so a 1 here skips the word
                next_st.phase = (data_in == sdsc_pkg::OP_WRITE) ? sdsc_pkg::SDSC_ADDR : sdsc_pkg::SDSC_SKIP;
            end
            else if (pos < sdsc_pkg::POS_PAYLOAD)
            begin
                next_st.addr = {st.addr[0], data_in};
                if (pos == sdsc_pkg::POS_ADDR_LO && st.phase == sdsc_pkg::SDSC_ADDR)
                begin
                    next_st.phase = sdsc_pkg::SDSC_DATA;
                end
            end
            else if (st.phase == sdsc_pkg::SDSC_DATA)
            begin
                // Shift straight into the target, no holding stage
                unique case (st.addr)
                    sdsc_pkg::ADDR_TEST_CONTROL: next_st.regs.test_control = {st.regs.test_control[3:0], data_in};
                    sdsc_pkg::ADDR_RED_DELAY: next_st.regs.red_delay = {st.regs.red_delay[3:0], data_in};
                    sdsc_pkg::ADDR_GREEN_DELAY: next_st.regs.green_delay = {st.regs.green_delay[3:0], data_in};
                    sdsc_pkg::ADDR_BLUE_DELAY: next_st.regs.blue_delay = {st.regs.blue_delay[3:0], data_in};
                endcase
            end
            if (pos == sdsc_pkg::POS_LAST)
            begin
                next_st.phase = sdsc_pkg::SDSC_IDLE;
            end
        end
    end

    // Falling edge of the programming clock is the only sampling edge
    always_ff @(negedge clk_n_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign regs_out = st.regs;
endmodule : sdsc_serial_rx

// ==== core/sdsc_top.sv ====
// Top of the skew delay serial configuration block.
// Assumes CLK_IN at 50 MHz, PROG_CLK_IN from the host at up to 10 MHz.
// What this block does
// - Serial data is sampled only on falling programming clock edges.
// - Select is active low; words are accepted only while it is low.
// - First bit is the operation; 0 writes, reads are unsupported.
// - Next two bits select test, red, green or blue register.
// - Five following bits shift into the selected register, MSB first.
// - After eight bits, further bits start a new word.
// - Bits go straight into the destination registers, no load strobe.
// - All registers clear to zero at power-up.
// - Each code unit adds one 2 ns all-pass stage.
// - Test register bit 0 selects normal or test mode.
// - Test register bits 1 to 4 give a signed slicing level.
// - In test mode green shows the slicing level, red/blue own delay.
// - Normal mode detectors compare channel pairs, sign by lead or lag.
// - Chip enable high enables operation.
// - Gain select high gives gain two, otherwise one.
`timescale 1ns/100ps
module sdsc_top (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic PROG_CLK_IN,
    input wire logic SERIAL_SELECT_N_IN,
    input wire logic SERIAL_IN_LINE_IN,
    input wire logic CHIP_ON_PIN_IN,
    input wire logic GAIN_DOUBLE_SELECT_IN,
    input wire logic SLICED_RED_IN,
    input wire logic SLICED_GREEN_IN,
    input wire logic SLICED_BLUE_IN,
    output logic TEST_MODE_OUT,
    output logic [3:0] SLICE_LEVEL_OUT,
    output logic [4:0] RED_STAGES_OUT,
    output logic [4:0] GREEN_STAGES_OUT,
    output logic [4:0] BLUE_STAGES_OUT,
    output logic GREEN_SHOWS_SLICE_OUT,
    output logic CHIP_ON_OUT,
    output logic GAIN_DOUBLE_OUT,
    output logic [1:0] SKEW_DETECT_RED_OUT,
    output logic [1:0] SKEW_DETECT_GREEN_OUT,
    output logic [1:0] SKEW_DETECT_BLUE_OUT
);
    // ****************************************
    // Reset release and link reset
    // ****************************************
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign rst_n = rst_sync[1];

    // Link side resets straight from the pin: its clock may not run
    sdsc_pkg::sdsc_regs_s link_regs;
    sdsc_serial_rx u_rx (
        .clk_n_in(PROG_CLK_IN),
        .rst_n_in(RSTN_IN),
        .select_n_in(SERIAL_SELECT_N_IN),
        .data_in(SERIAL_IN_LINE_IN),
        .regs_out(link_regs)
    );

    // ****************************************
    // Core state
    // ****************************************
    typedef struct packed {
        logic [1:0][19:0] reg_sync;
        logic [1:0][19:0] reg_seen;
        logic [19:0] regs;
        logic [1:0][4:0] pin_sync;
        sdsc_pkg::sdsc_ctrl_s ctrl;
        logic [2:0][1:0] detect;
    } sdsc_core_s;

    sdsc_core_s st;
    sdsc_core_s next_st;

    // Pin bits: 0 chip on, 1 gain, 2 red, 3 green, 4 blue
    logic [4:0] pins_raw;
    assign pins_raw = {SLICED_BLUE_IN, SLICED_GREEN_IN, SLICED_RED_IN, GAIN_DOUBLE_SELECT_IN, CHIP_ON_PIN_IN};

    // Encode lead/lag of a against b: 01 positive, 11 negative, 00 none
    function automatic logic [1:0] sdsc_overlap(input logic a, input logic b);
        logic [1:0] r;
        r = 2'h0;
        if (a && !b)
        begin
            r = 2'h1;
        end
        else if (b && !a)
        begin
            r = 2'h3;
        end
        return r;
    endfunction : sdsc_overlap

    sdsc_pkg::sdsc_regs_s live;
    logic [4:0] pins;
    logic [2:0] sl;

    always_comb
    begin
        next_st = st;
        next_st.reg_sync = {st.reg_sync[0], link_regs};
        next_st.pin_sync = {st.pin_sync[0], pins_raw};
        // Words cross as levels; adopt only after two equal samples so a
        // value caught mid-shift never reaches the analog controls
        next_st.reg_seen = {st.reg_seen[0], st.reg_sync[1]};
        if (st.reg_seen[0] == st.reg_seen[1])
        begin
            next_st.regs = st.reg_seen[1];
        end
        live = sdsc_pkg::sdsc_regs_s'(st.regs);
        pins = st.pin_sync[1];
        sl = pins[4:2];
        next_st.ctrl.chip_on = pins[0];
        next_st.ctrl.gain_double = pins[1];
        next_st.ctrl.test_mode = live.test_control[sdsc_pkg::TEST_MODE_BIT];
        next_st.ctrl.slice_code = live.test_control[sdsc_pkg::SLICE_MSB:sdsc_pkg::SLICE_LSB];
        // One all-pass stage per code unit, 2 ns each
        next_st.ctrl.red_stages = live.red_delay;
        next_st.ctrl.green_stages = live.green_delay;
        next_st.ctrl.blue_stages = live.blue_delay;
        if (!pins[0])
        begin
            next_st.detect = '0;
        end
        else if (live.test_control[sdsc_pkg::TEST_MODE_BIT])
        begin
            // Own-channel delay is below digital resolution, so the detectors stay quiet
            next_st.detect[0] = 2'h0;
            next_st.detect[1] = 2'h0;
            next_st.detect[2] = 2'h0;
        end
        else
        begin
            next_st.detect[0] = sdsc_overlap(sl[0], sl[1]);
            next_st.detect[1] = sdsc_overlap(sl[1], sl[2]);
            next_st.detect[2] = sdsc_overlap(sl[2], sl[0]);
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign TEST_MODE_OUT = st.ctrl.test_mode;
    assign SLICE_LEVEL_OUT = st.ctrl.slice_code;
    assign RED_STAGES_OUT = st.ctrl.red_stages;
    assign GREEN_STAGES_OUT = st.ctrl.green_stages;
    assign BLUE_STAGES_OUT = st.ctrl.blue_stages;
    assign GREEN_SHOWS_SLICE_OUT = st.ctrl.test_mode;
    assign CHIP_ON_OUT = st.ctrl.chip_on;
    assign GAIN_DOUBLE_OUT = st.ctrl.gain_double;
    assign SKEW_DETECT_RED_OUT = st.detect[0];
    assign SKEW_DETECT_GREEN_OUT = st.detect[1];
    assign SKEW_DETECT_BLUE_OUT = st.detect[2];
endmodule : sdsc_top

// ==== test/sdsc_sva.sv ====
// Checker for the serial configuration top, bound to its ports.
// Assumes the select pin idles high and the bench resets at start.
`timescale 1ns/100ps
module sdsc_sva (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic SERIAL_SELECT_N_IN,
    input wire logic CHIP_ON_PIN_IN,
    input wire logic GAIN_DOUBLE_SELECT_IN,
    input wire logic SLICED_RED_IN,
    input wire logic SLICED_GREEN_IN,
    input wire logic SLICED_BLUE_IN,
    input wire logic TEST_MODE_OUT,
    input wire logic [3:0] SLICE_LEVEL_OUT,
    input wire logic [4:0] RED_STAGES_OUT,
    input wire logic [4:0] GREEN_STAGES_OUT,
    input wire logic [4:0] BLUE_STAGES_OUT,
    input wire logic GREEN_SHOWS_SLICE_OUT,
    input wire logic CHIP_ON_OUT,
    input wire logic GAIN_DOUBLE_OUT,
    input wire logic [1:0] SKEW_DETECT_RED_OUT,
    input wire logic [1:0] SKEW_DETECT_GREEN_OUT,
    input wire logic [1:0] SKEW_DETECT_BLUE_OUT
);
    // ****************************************
    // Helpers: cycles since select rose, cycles since reset
    // ****************************************
    logic [3:0] idle_cnt;
    logic [3:0] up_cnt;
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            idle_cnt <= 4'h0;
            up_cnt <= 4'h0;
        end
        else
        begin
            idle_cnt <= !SERIAL_SELECT_N_IN ? 4'h0 : ((idle_cnt == 4'hf) ? idle_cnt : idle_cnt + 4'h1);
            up_cnt <= (up_cnt == 4'hf) ? up_cnt : up_cnt + 4'h1;
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    a_green_slice: assert property (GREEN_SHOWS_SLICE_OUT == TEST_MODE_OUT)
        else $error("green routing differs from mode");
    a_test_quiet: assert property (TEST_MODE_OUT |-> SKEW_DETECT_RED_OUT == 2'h0 && SKEW_DETECT_BLUE_OUT == 2'h0)
        else $error("detector active in test mode");
    a_skew_legal: assert property (SKEW_DETECT_RED_OUT != 2'h2 && SKEW_DETECT_GREEN_OUT != 2'h2
        && SKEW_DETECT_BLUE_OUT != 2'h2)
        else $error("illegal detector code");
    a_reset_clear: assert property ($rose(RSTN_IN) |-> {TEST_MODE_OUT, SLICE_LEVEL_OUT, RED_STAGES_OUT,
        GREEN_STAGES_OUT, BLUE_STAGES_OUT} == 20'h00000)
        else $error("registers not clear after reset");
    a_chip_follow: assert property ((up_cnt == 4'hf && $stable(CHIP_ON_PIN_IN)) [*4] |->
        CHIP_ON_OUT == CHIP_ON_PIN_IN)
        else $error("chip enable not followed");
    a_gain_follow: assert property ((up_cnt == 4'hf && $stable(GAIN_DOUBLE_SELECT_IN)) [*4] |->
        GAIN_DOUBLE_OUT == GAIN_DOUBLE_SELECT_IN)
        else $error("gain select not followed");
    a_stage_quiet: assert property ($changed({RED_STAGES_OUT, GREEN_STAGES_OUT, BLUE_STAGES_OUT}) |->
        idle_cnt <= 4'h9)
        else $error("delay changed without a word");
    a_mode_settle: assert property ($changed({TEST_MODE_OUT, SLICE_LEVEL_OUT}) |-> idle_cnt <= 4'h9)
        else $error("test register changed without a word");
    // Sliced inputs reach the detectors three clock edges later
    a_red_overlap: assert property (CHIP_ON_OUT && !TEST_MODE_OUT |-> SKEW_DETECT_RED_OUT ==
        (($past(SLICED_RED_IN, 3) == $past(SLICED_GREEN_IN, 3)) ? 2'h0 : ($past(SLICED_RED_IN, 3) ? 2'h1 : 2'h3)))
        else $error("red detector wrong");
    a_green_overlap: assert property (CHIP_ON_OUT && !TEST_MODE_OUT |-> SKEW_DETECT_GREEN_OUT ==
        (($past(SLICED_GREEN_IN, 3) == $past(SLICED_BLUE_IN, 3)) ? 2'h0 : ($past(SLICED_GREEN_IN, 3) ? 2'h1 : 2'h3)))
        else $error("green detector wrong");
    a_blue_overlap: assert property (CHIP_ON_OUT && !TEST_MODE_OUT |-> SKEW_DETECT_BLUE_OUT ==
        (($past(SLICED_BLUE_IN, 3) == $past(SLICED_RED_IN, 3)) ? 2'h0 : ($past(SLICED_BLUE_IN, 3) ? 2'h1 : 2'h3)))
        else $error("blue detector wrong");
endmodule : sdsc_sva

bind sdsc_top sdsc_sva u_sva (.*);

// ==== test/sdsc_host.sv ====
// Host model driving select, data and programming clock.
// Assumes the caller waits for each call to return.
`timescale 1ns/100ps
module sdsc_host (
    output logic sclk_out,
    output logic sel_n_out,
    output logic data_out
);
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        data_out = 1'b1;
    end
    // Clock stands low outside frames; 6 ns period exceeds the host limit on purpose
    task automatic send(input logic [15:0] bits, input int n, input logic hold_hi);
        sel_n_out = hold_hi;
        #12;
        for (int i = 0; i < n; i++)
        begin
            #1 data_out = bits[15 - i];
            #2 sclk_out = 1'b1;
            #3 sclk_out = 1'b0;
        end
        #12 sel_n_out = 1'b1;
        data_out = ~data_out;
    endtask : send
endmodule : sdsc_host

// ==== test/sdsc_tb_top.sv ====
// Self-checking bench for the serial configuration top.
// Assumes the host model in sdsc_host and the bound checker.
`timescale 1ns/100ps
module sdsc_tb_top;
    logic CLK_IN = 1'b0;
    logic RSTN_IN = 1'b0;
    logic CHIP_ON_PIN_IN = 1'b0;
    logic GAIN_DOUBLE_SELECT_IN = 1'b0;
    logic SLICED_RED_IN = 1'b0;
    logic SLICED_GREEN_IN = 1'b0;
    logic SLICED_BLUE_IN = 1'b0;
    logic sclk, sel_n, serial_in_line, test_mode, shows, chip_on, gain2;
    logic [3:0] slice;
    logic [4:0] red, green, blue;
    logic [1:0] det_r, det_g, det_b;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    wire [19:0] seen = {slice, test_mode, red, green, blue};
    // Row: select held high, word, expected {test, red, green, blue}
    logic [28:0] rows [7] = '{{1'h0, 8'h3e, 20'h07800}, {1'h0, 8'h41, 20'h07820}, {1'h0, 8'h75, 20'h07835},
        {1'h0, 8'h11, 20'h8f835}, {1'h0, 8'h0e, 20'h77835}, {1'h0, 8'ha0, 20'h77835}, {1'h1, 8'h20, 20'h77835}};
    sdsc_host host (.sclk_out(sclk), .sel_n_out(sel_n), .data_out(serial_in_line));
    sdsc_top dut (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .PROG_CLK_IN(sclk), .SERIAL_SELECT_N_IN(sel_n),
        .SERIAL_IN_LINE_IN(serial_in_line), .CHIP_ON_PIN_IN(CHIP_ON_PIN_IN), .GAIN_DOUBLE_SELECT_IN(GAIN_DOUBLE_SELECT_IN),
        .SLICED_RED_IN(SLICED_RED_IN), .SLICED_GREEN_IN(SLICED_GREEN_IN), .SLICED_BLUE_IN(SLICED_BLUE_IN),
        .TEST_MODE_OUT(test_mode), .SLICE_LEVEL_OUT(slice), .RED_STAGES_OUT(red), .GREEN_STAGES_OUT(green),
        .BLUE_STAGES_OUT(blue), .GREEN_SHOWS_SLICE_OUT(shows), .CHIP_ON_OUT(chip_on), .GAIN_DOUBLE_OUT(gain2),
        .SKEW_DETECT_RED_OUT(det_r), .SKEW_DETECT_GREEN_OUT(det_g), .SKEW_DETECT_BLUE_OUT(det_b));
    always #10 CLK_IN = ~CLK_IN;
    // ****************************************
    // Video stimulus and hang guard
    // ****************************************
    always @(negedge CLK_IN)
    begin
        cyc <= cyc + 1;
        SLICED_RED_IN <= cyc[3];
        SLICED_GREEN_IN <= cyc[4];
        SLICED_BLUE_IN <= cyc[3] ^ cyc[5];
        if (cyc == 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic check(input string name, input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge CLK_IN);
    endtask : wait_cyc
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        wait_cyc(5);
        RSTN_IN = 1'b1;
        wait_cyc(4);
        check("reset", seen, 20'h00000);
        for (int i = 0; i < 7; i++)
        begin
            host.send({rows[i][27:20], 8'h00}, 8, rows[i][28]);
            wait_cyc(12);
            check("regs", seen, rows[i][19:0]);
            check("green_slice", {19'h00000, shows}, {19'h00000, rows[i][15]});
            $display("row %0d done", i);
        end
        host.send(16'h2377, 16, 1'b0);
        wait_cyc(12);
        check("two_words", seen, 20'h70c37);
        host.send(16'h3800, 5, 1'b0);
        wait_cyc(12);
        check("short_word", {15'h0000, red}, 20'h0000f);
        host.send(16'h2400, 8, 1'b0);
        wait_cyc(12);
        check("fresh_word", {15'h0000, red}, 20'h00004);
        $display("framing tests done");
        for (int k = 0; k < 4; k++)
        begin
            CHIP_ON_PIN_IN = k[0];
            GAIN_DOUBLE_SELECT_IN = k[1];
            wait_cyc(5);
            check("pins", {18'h00000, chip_on, gain2}, {18'h00000, k[0], k[1]});
        end
        // Test mode with the chip on, then zero delay on the latest channel
        host.send(16'h0140, 16, 1'b0);
        wait_cyc(12);
        check("test_regs", seen, 20'h09017);
        check("test_detect", {16'h0000, det_r, det_b}, 20'h00000);
        check("test_green", {19'h00000, shows}, 20'h00001);
        $display("test mode done");
        RSTN_IN = 1'b0;
        wait_cyc(2);
        check("mid_reset", seen, 20'h00000);
        RSTN_IN = 1'b1;
        wait_cyc(4);
        check("after_reset", seen, 20'h00000);
        $display("pin and reset tests done");
        wrap_up();
    end
endmodule : sdsc_tb_top
